// file: input_function_pkg.sv
// Constants and types shared by the input function decoder and its counters
package input_function_pkg;
    localparam int NUM_TERMS = 10;
    localparam int CODE_W = 6;
    localparam int COUNT_W = 32;
    localparam int FAST_IDX = 9;

    typedef logic [NUM_TERMS-1:0] term_vec_t;
    typedef logic [NUM_TERMS-1:0][CODE_W-1:0] code_array_t;
    typedef logic [COUNT_W-1:0] count_t;
    typedef logic [CODE_W-1:0] code_t;
    typedef logic [1:0] cmd_src_t;
    typedef logic [1:0] gain_src_t;

    localparam code_t FN_RAMP_HOLD = 6'h15;
    localparam code_t FN_LOOP_PAUSE = 6'h16;
    localparam code_t FN_SEQ_RESET = 6'h17;
    localparam code_t FN_SWING_PAUSE = 6'h18;
    localparam code_t FN_COUNT_IN = 6'h19;
    localparam code_t FN_COUNT_RESET = 6'h1A;
    localparam code_t FN_LENGTH_IN = 6'h1B;
    localparam code_t FN_LENGTH_RESET = 6'h1C;
    localparam code_t FN_TORQUE_INHIBIT = 6'h1D;
    localparam code_t FN_PULSE_IN = 6'h1E;
    localparam code_t FN_RESERVED = 6'h1F;
    localparam code_t FN_DC_BRAKE_NOW = 6'h20;
    localparam code_t FN_EXT_FAULT_NC = 6'h21;
    localparam code_t FN_FREQ_LOCK = 6'h22;
    localparam code_t FN_LOOP_DIR_INV = 6'h23;
    localparam code_t FN_EXT_STOP_1 = 6'h24;
    localparam code_t FN_SRC_SWITCH_2 = 6'h25;
    localparam code_t FN_INTEGRAL_PAUSE = 6'h26;
    localparam code_t FN_MOTOR_SELECT = 6'h29;
    localparam code_t FN_GAIN_SWITCH = 6'h2B;
    localparam code_t FN_MODE_SWITCH = 6'h2E;
    localparam code_t FN_EMERGENCY_STOP = 6'h2F;
    localparam code_t FN_EXT_STOP_2 = 6'h30;
    localparam code_t FN_DECEL_BRAKE = 6'h31;

    localparam cmd_src_t SRC_PANEL = 2'h0;
    localparam cmd_src_t SRC_TERMINAL = 2'h1;
    localparam cmd_src_t SRC_COMM = 2'h2;

    localparam gain_src_t GAIN_SRC_TERMINAL = 2'h1;

    localparam logic MODE_SPEED = 1'b0;
    localparam logic MODE_TORQUE = 1'b1;

    localparam count_t COUNT_ZERO = 32'h0000_0000;
    localparam count_t COUNT_ONE = 32'h0000_0001;
    localparam term_vec_t TERM_ZERO = 10'h000;
endpackage : input_function_pkg

// file: count_if.sv
// Increment and clear strobes with the resulting count value
interface count_if;
    import input_function_pkg::*;
    logic inc;
    logic clr;
    count_t value;
    modport ctrl (output inc, output clr, input value);
    modport cnt (input inc, input clr, output value);
endinterface : count_if

// file: event_counter.sv
// Event or length accumulator with synchronous clear
module event_counter (
    input wire logic core_clk,
    input wire logic resetn,
    count_if.cnt port
);
    import input_function_pkg::*;

    typedef struct packed {
        count_t value;
    } cnt_state_t;

    cnt_state_t state_d;
    cnt_state_t state_q;

    always_comb begin
        state_d = state_q;
        if (port.clr) begin
            state_d.value = COUNT_ZERO;
        end else if (port.inc) begin
            state_d.value = state_q.value + COUNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= '{value: COUNT_ZERO};
        end else begin
            state_q <= state_d;
        end
    end

    assign port.value = state_q.value;
endmodule : event_counter

// file: drive_input_function_decoder.sv
// Decoder of per-terminal function codes into drive control actions
// Function
// - Ramp-hold terminal freezes output frequency; only a stop command still acts.
// - Loop-pause terminal suspends regulation and holds the present frequency.
// - Sequence-reset terminal returns the step sequencer to its initial state.
// - Swing-pause terminal stops wobbling; only the centre frequency is output.
// - Count-input terminals add one event per cycle with a closure, none while counter-reset is on.
// - Counter-reset terminal clears the event counter to zero.
// - Length-input feeds length accumulator; length-reset clears it.
// - Torque-inhibit terminal forces speed control instead of torque control.
// - Pulse-input code works only on fast input; next code reserved.
// - Immediate braking terminal enters DC braking directly without ramping.
// - Normally-closed fault terminal reports external fault and stops drive.
// - Frequency-lock terminal blocks every frequency reference change.
// - Loop-direction terminal inverts the configured regulator direction.
// - First external stop acts only under panel control, like panel stop key.
// - Under terminal control, second source-switch moves authority to communication.
// - Integral-pause terminal freezes integral term; P and D keep acting.
// - Motor-select terminal chooses between two motor parameter sets.
// - With switch source 1, terminal picks primary or secondary gain set.
// - Mode-switch terminal off: configured mode; on: the other mode.
// - Emergency stop: shortest stop, current held at upper limit throughout.
// - Second external stop ramps down with fourth deceleration time in any source.
// - Ramp-then-brake: decelerate to braking start frequency, then DC brake.
module drive_input_function_decoder (
    input wire logic core_clk,
    input wire logic resetn,
    input wire input_function_pkg::term_vec_t term_level,
    input wire input_function_pkg::code_array_t func_code,
    input wire logic stop_cmd,
    input wire logic fault_clear,
    input wire logic motor_stopped,
    input wire input_function_pkg::cmd_src_t cmd_source_setting,
    input wire logic loop_direction_setting,
    input wire logic default_control_mode_setting,
    input wire input_function_pkg::gain_src_t gain_set_switch_source,
    output logic hold_freq,
    output logic loop_pause,
    output logic seq_reset,
    output logic swing_pause,
    output input_function_pkg::count_t event_count,
    output input_function_pkg::count_t length_count,
    output logic control_mode,
    output logic pulse_train_enable,
    output logic fast_pulse_input,
    output logic dc_brake_now,
    output logic external_fault_report,
    output logic fault_stop,
    output logic freq_change_block,
    output logic loop_direction,
    output logic panel_stop_req,
    output input_function_pkg::cmd_src_t cmd_source,
    output logic integral_freeze,
    output logic motor_select,
    output logic gain_select,
    output logic emergency_stop,
    output logic current_limit_hold,
    output logic decel4_stop,
    output logic decel_brake
);
    import input_function_pkg::*;

    // Length strobes travel as one pair
    typedef struct packed {
        logic inc;
        logic clr;
    } len_pair_t;

    // Every flag of the decoder lives in this one register
    typedef struct packed {
        term_vec_t lvl_prev;
        logic hold_freq;
        logic loop_pause;
        logic seq_reset;
        logic swing_pause;
        logic control_mode;
        logic pulse_en;
        logic pulse_edge;
        logic dc_brake;
        logic ext_fault;
        logic freq_lock;
        logic loop_dir;
        logic panel_stop;
        cmd_src_t cmd_src;
        logic int_freeze;
        logic motor_sel;
        logic gain_sel;
        logic estop;
        logic stop4;
        logic decel_brake;
        logic cnt_inc;
        logic cnt_clr;
        len_pair_t len;
    } dec_state_t;

    dec_state_t state_d;
    dec_state_t state_q;

    // Two alike counters, one for events and one for length
    count_if ev_if ();
    count_if len_if ();

    // Codes this block acts on; every other value, the reserved one too, is inert
    function automatic logic code_listed(input code_t code);
        logic listed;
        case (code)
            FN_RAMP_HOLD,
            FN_LOOP_PAUSE,
            FN_SEQ_RESET,
            FN_SWING_PAUSE,
            FN_COUNT_IN,
            FN_COUNT_RESET,
            FN_LENGTH_IN,
            FN_LENGTH_RESET,
            FN_TORQUE_INHIBIT,
            FN_PULSE_IN,
            FN_DC_BRAKE_NOW,
            FN_EXT_FAULT_NC,
            FN_FREQ_LOCK,
            FN_LOOP_DIR_INV,
            FN_EXT_STOP_1,
            FN_SRC_SWITCH_2,
            FN_INTEGRAL_PAUSE,
            FN_MOTOR_SELECT,
            FN_GAIN_SWITCH,
            FN_MODE_SWITCH,
            FN_EMERGENCY_STOP,
            FN_EXT_STOP_2,
            FN_DECEL_BRAKE: begin
                listed = 1'b1;
            end
            default: begin
                listed = 1'b0;
            end
        endcase
        return listed;
    endfunction : code_listed

    // True when any terminal carries the code and is on
    function automatic logic func_on(input code_array_t codes, input term_vec_t lvl, input code_t code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            if (code_listed(codes[i]) && codes[i] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : func_on

    // True when a terminal carrying the code turns on this cycle
    function automatic logic func_rise(input code_array_t codes, input term_vec_t lvl, input term_vec_t prev,
                                       input code_t code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            if (code_listed(codes[i]) && codes[i] == code && lvl[i] && !prev[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : func_rise

    // Decoded actions: act_ for levels, rise_ for closures
    logic act_ramp_hold;
    logic act_loop_pause;
    logic rise_seq_reset;
    logic act_swing_pause;
    logic rise_count;
    logic act_count_reset;
    logic rise_length;
    logic act_length_reset;
    logic act_torque_inhibit;
    logic pulse_cfg;
    logic rise_fast;
    logic act_dc_brake;
    logic rise_fault;
    logic act_freq_lock;
    logic act_loop_dir;
    logic rise_stop1;
    logic act_src_switch;
    logic act_int_pause;
    logic act_motor_sel;
    logic act_gain_switch;
    logic act_mode_switch;
    logic rise_estop;
    logic rise_stop2;
    logic act_decel_brake;

    // Codes outside the listed set, the reserved one among them, match no branch
    always_comb begin
        act_ramp_hold = func_on(func_code, term_level, FN_RAMP_HOLD);
        act_loop_pause = func_on(func_code, term_level, FN_LOOP_PAUSE);
        rise_seq_reset = func_rise(func_code, term_level, state_q.lvl_prev, FN_SEQ_RESET);
        act_swing_pause = func_on(func_code, term_level, FN_SWING_PAUSE);
        rise_count = func_rise(func_code, term_level, state_q.lvl_prev, FN_COUNT_IN);
        act_count_reset = func_on(func_code, term_level, FN_COUNT_RESET);
        rise_length = func_rise(func_code, term_level, state_q.lvl_prev, FN_LENGTH_IN);
        act_length_reset = func_on(func_code, term_level, FN_LENGTH_RESET);
        act_torque_inhibit = func_on(func_code, term_level, FN_TORQUE_INHIBIT);
        act_dc_brake = func_on(func_code, term_level, FN_DC_BRAKE_NOW);
        rise_fault = func_rise(func_code, term_level, state_q.lvl_prev, FN_EXT_FAULT_NC);
        act_freq_lock = func_on(func_code, term_level, FN_FREQ_LOCK);
        act_loop_dir = func_on(func_code, term_level, FN_LOOP_DIR_INV);
        rise_stop1 = func_rise(func_code, term_level, state_q.lvl_prev, FN_EXT_STOP_1);
        act_src_switch = func_on(func_code, term_level, FN_SRC_SWITCH_2);
        act_int_pause = func_on(func_code, term_level, FN_INTEGRAL_PAUSE);
        act_motor_sel = func_on(func_code, term_level, FN_MOTOR_SELECT);
        act_gain_switch = func_on(func_code, term_level, FN_GAIN_SWITCH);
        act_mode_switch = func_on(func_code, term_level, FN_MODE_SWITCH);
        rise_estop = func_rise(func_code, term_level, state_q.lvl_prev, FN_EMERGENCY_STOP);
        rise_stop2 = func_rise(func_code, term_level, state_q.lvl_prev, FN_EXT_STOP_2);
        act_decel_brake = func_on(func_code, term_level, FN_DECEL_BRAKE);
        // Pulse mode only on the fast input; the same code elsewhere is ignored
        pulse_cfg = (func_code[FAST_IDX] == FN_PULSE_IN);
        rise_fast = term_level[FAST_IDX] && !state_q.lvl_prev[FAST_IDX];
    end

    always_comb begin
        state_d = state_q;
        // Edge history is the level seen at the last edge
        state_d.lvl_prev = term_level;

        // Hold present frequency unless a stop is commanded
        state_d.hold_freq = act_ramp_hold && !stop_cmd;
        state_d.loop_pause = act_loop_pause;
        state_d.seq_reset = rise_seq_reset;
        state_d.swing_pause = act_swing_pause;

        // One count per closure edge
        state_d.cnt_inc = rise_count;
        state_d.cnt_clr = act_count_reset;
        state_d.len.inc = rise_length;
        state_d.len.clr = act_length_reset;

        // Inhibit beats the mode switch; otherwise switch flips the default
        if (act_torque_inhibit) begin
            state_d.control_mode = MODE_SPEED;
        end else if (act_mode_switch) begin
            state_d.control_mode = ~default_control_mode_setting;
        end else begin
            state_d.control_mode = default_control_mode_setting;
        end

        state_d.pulse_en = pulse_cfg;
        state_d.pulse_edge = pulse_cfg && rise_fast;

        // Direct braking, no ramp involved
        state_d.dc_brake = act_dc_brake;

        // Fault latches until cleared; a new fault edge wins over the clear
        if (rise_fault) begin
            state_d.ext_fault = 1'b1;
        end else if (fault_clear) begin
            state_d.ext_fault = 1'b0;
        end

        state_d.freq_lock = act_freq_lock;
        state_d.loop_dir = loop_direction_setting ^ act_loop_dir;

        // Stop key equivalent only under panel authority
        state_d.panel_stop = rise_stop1 && (cmd_source_setting == SRC_PANEL);

        if (cmd_source_setting == SRC_TERMINAL && act_src_switch) begin
            state_d.cmd_src = SRC_COMM;
        end else begin
            state_d.cmd_src = cmd_source_setting;
        end

        state_d.int_freeze = act_int_pause;
        state_d.motor_sel = act_motor_sel;
        state_d.gain_sel = (gain_set_switch_source == GAIN_SRC_TERMINAL) && act_gain_switch;

        // Stops run to completion once begun; a new edge wins over completion
        if (rise_estop) begin
            state_d.estop = 1'b1;
        end else if (motor_stopped) begin
            state_d.estop = 1'b0;
        end
        if (rise_stop2) begin
            state_d.stop4 = 1'b1;
        end else if (motor_stopped) begin
            state_d.stop4 = 1'b0;
        end

        state_d.decel_brake = act_decel_brake;
    end

    // Reset also clears the edge history, so a held terminal gives an edge
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Strobe flops feed the counters, so counts trail levels by two cycles
    assign ev_if.inc = state_q.cnt_inc;
    assign ev_if.clr = state_q.cnt_clr;
    assign len_if.inc = state_q.len.inc;
    assign len_if.clr = state_q.len.clr;

    event_counter u_event_counter (
        .core_clk(core_clk),
        .resetn(resetn),
        .port(ev_if.cnt)
    );

    event_counter u_length_counter (
        .core_clk(core_clk),
        .resetn(resetn),
        .port(len_if.cnt)
    );

    // Outputs taken straight from the state register, the two counts from the counters
    assign hold_freq = state_q.hold_freq;
    assign loop_pause = state_q.loop_pause;
    assign seq_reset = state_q.seq_reset;
    assign swing_pause = state_q.swing_pause;
    assign event_count = ev_if.value;
    assign length_count = len_if.value;
    assign control_mode = state_q.control_mode;
    assign pulse_train_enable = state_q.pulse_en;
    assign fast_pulse_input = state_q.pulse_edge;
    assign dc_brake_now = state_q.dc_brake;
    assign external_fault_report = state_q.ext_fault;
    assign fault_stop = state_q.ext_fault;
    assign freq_change_block = state_q.freq_lock;
    assign loop_direction = state_q.loop_dir;
    assign panel_stop_req = state_q.panel_stop;
    assign cmd_source = state_q.cmd_src;
    assign integral_freeze = state_q.int_freeze;
    assign motor_select = state_q.motor_sel;
    assign gain_select = state_q.gain_sel;
    assign emergency_stop = state_q.estop;
    assign current_limit_hold = state_q.estop;
    assign decel4_stop = state_q.stop4;
    assign decel_brake = state_q.decel_brake;
endmodule : drive_input_function_decoder

// file: switch_bank.sv
// External switch contacts that open and close the input terminals
module switch_bank (
    input wire logic core_clk,
    input wire input_function_pkg::term_vec_t want,
    output input_function_pkg::term_vec_t term_level = 10'h000
);
    timeunit 1ns;
    timeprecision 1ps;
    import input_function_pkg::*;
    // Contacts move just after the edge, never on it
    always @(posedge core_clk) begin
        term_level <= #1 want;
    end
endmodule : switch_bank

// file: dec_monitor.sv
// Concurrent checks on the input function decoder ports
module dec_monitor (
    input wire logic core_clk,
    input wire logic resetn,
    input wire input_function_pkg::term_vec_t term_level,
    input wire input_function_pkg::code_array_t func_code,
    input wire logic stop_cmd,
    input wire input_function_pkg::cmd_src_t cmd_source_setting,
    input wire logic loop_direction_setting,
    input wire logic default_control_mode_setting,
    input wire logic hold_freq,
    input wire logic seq_reset,
    input wire input_function_pkg::count_t event_count,
    input wire logic control_mode,
    input wire logic pulse_train_enable,
    input wire logic external_fault_report,
    input wire logic fault_stop,
    input wire logic loop_direction,
    input wire logic panel_stop_req,
    input wire input_function_pkg::cmd_src_t cmd_source,
    input wire logic emergency_stop,
    input wire logic current_limit_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    import input_function_pkg::*;
    // Any terminal carrying this code is on
    function automatic logic act(input code_t c);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            r = r | (term_level[i] & (func_code[i] == c));
        end
        return r;
    endfunction : act
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_hold_output: assert property (1 |=> hold_freq == ($past(act(FN_RAMP_HOLD)) && !$past(stop_cmd)))
        else $error("hold output wrong");
    chk_seq_pulse: assert property (seq_reset |=> !seq_reset)
        else $error("sequence reset longer than one cycle");
    chk_count_step: assert property (event_count != $past(event_count)
        |-> event_count == $past(event_count) + COUNT_ONE || event_count == COUNT_ZERO)
        else $error("event count jumped");
    chk_count_clear: assert property (act(FN_COUNT_RESET) |-> ##2 event_count == COUNT_ZERO)
        else $error("event count not cleared");
    chk_mode_select: assert property (1 |=> control_mode == ($past(act(FN_TORQUE_INHIBIT)) ? MODE_SPEED
        : ($past(act(FN_MODE_SWITCH)) ^ $past(default_control_mode_setting))))
        else $error("control mode wrong");
    chk_pulse_enable: assert property (1 |=> pulse_train_enable ==
        ($past(func_code[FAST_IDX]) == FN_PULSE_IN))
        else $error("pulse enable wrong");
    chk_fault_set: assert property ($rose(act(FN_EXT_FAULT_NC)) |=> external_fault_report && fault_stop)
        else $error("external fault not raised");
    chk_fault_pair: assert property (fault_stop == external_fault_report)
        else $error("fault stop differs from report");
    chk_loop_dir: assert property (1 |=> loop_direction ==
        ($past(loop_direction_setting) ^ $past(act(FN_LOOP_DIR_INV))))
        else $error("loop direction wrong");
    chk_panel_stop: assert property (panel_stop_req
        |-> $past(cmd_source_setting) == SRC_PANEL && $past(act(FN_EXT_STOP_1)))
        else $error("panel stop outside panel mode");
    chk_source_switch: assert property (1 |=> cmd_source == (($past(cmd_source_setting) == SRC_TERMINAL
        && $past(act(FN_SRC_SWITCH_2))) ? SRC_COMM : $past(cmd_source_setting)))
        else $error("command source wrong");
    chk_emerg_set: assert property ($rose(act(FN_EMERGENCY_STOP)) |=> emergency_stop && current_limit_hold)
        else $error("emergency stop not raised");
endmodule : dec_monitor
bind drive_input_function_decoder dec_monitor i_dec_monitor (.core_clk, .resetn, .term_level, .func_code,
    .stop_cmd, .cmd_source_setting, .loop_direction_setting, .default_control_mode_setting, .hold_freq,
    .seq_reset, .event_count, .control_mode, .pulse_train_enable, .external_fault_report, .fault_stop,
    .loop_direction, .panel_stop_req, .cmd_source, .emergency_stop, .current_limit_hold);

// file: testbench.sv
// Self-checking bench for the input function decoder
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import input_function_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic stop_cmd = 1'b0;
    logic fault_clear = 1'b0;
    logic motor_stopped = 1'b0;
    logic loop_direction_setting = 1'b0;
    logic default_control_mode_setting = 1'b0;
    term_vec_t want = TERM_ZERO;
    term_vec_t term_level;
    code_array_t func_code = {NUM_TERMS{6'h00}};
    cmd_src_t cmd_source_setting = SRC_PANEL;
    cmd_src_t cmd_source;
    gain_src_t gain_set_switch_source = 2'h0;
    logic hold_freq, loop_pause, seq_reset, swing_pause, control_mode, pulse_train_enable, fast_pulse_input;
    logic dc_brake_now, external_fault_report, fault_stop, freq_change_block, loop_direction, panel_stop_req;
    logic integral_freeze, motor_select, gain_select, emergency_stop, current_limit_hold, decel4_stop, decel_brake;
    count_t event_count, length_count;
    int n_errors = 0;
    int n_checks = 0;
    wire logic [7:0] lv = {hold_freq, loop_pause, swing_pause, dc_brake_now, freq_change_block,
        integral_freeze, motor_select, decel_brake};

    always #2 core_clk = ~core_clk;

    switch_bank i_switch_bank (.core_clk, .want, .term_level);
    drive_input_function_decoder i_drive_input_function_decoder (.core_clk, .resetn, .term_level, .func_code,
        .stop_cmd, .fault_clear, .motor_stopped, .cmd_source_setting, .loop_direction_setting,
        .default_control_mode_setting, .gain_set_switch_source, .hold_freq, .loop_pause, .seq_reset, .swing_pause,
        .event_count, .length_count, .control_mode, .pulse_train_enable, .fast_pulse_input, .dc_brake_now,
        .external_fault_report, .fault_stop, .freq_change_block, .loop_direction, .panel_stop_req, .cmd_source,
        .integral_freeze, .motor_select, .gain_select, .emergency_stop, .current_limit_hold, .decel4_stop,
        .decel_brake);

    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    // Switch moves one edge later, decoder answers on the next
    task automatic press(input int k, input logic v);
        want[k] = v;
        step(2);
    endtask : press

    task automatic t_levels;
        code_t c [8] = '{FN_RAMP_HOLD, FN_LOOP_PAUSE, FN_SWING_PAUSE, FN_DC_BRAKE_NOW, FN_FREQ_LOCK,
            FN_INTEGRAL_PAUSE, FN_MOTOR_SELECT, FN_DECEL_BRAKE};
        for (int i = 0; i < 8; i++) begin
            func_code[3] = c[i];
            press(3, 1'b1);
            chk({24'h0, lv}, 32'h1 << (7 - i));
            press(3, 1'b0);
            chk({24'h0, lv}, 32'h0);
        end
        func_code[3] = FN_RAMP_HOLD;
        stop_cmd = 1'b1;
        press(3, 1'b1);
        chk(hold_freq, 1'b0);
        stop_cmd = 1'b0;
        step(2);
        chk(hold_freq, 1'b1);
        press(3, 1'b0);
    endtask : t_levels
    task automatic t_count;
        func_code[0] = FN_COUNT_IN;
        func_code[1] = FN_COUNT_RESET;
        func_code[4] = FN_LENGTH_IN;
        func_code[5] = FN_LENGTH_RESET;
        repeat (3) begin
            press(0, 1'b1);
            press(0, 1'b0);
        end
        press(4, 1'b1);
        step(1);
        chk(event_count, 32'h3);
        chk(length_count, 32'h1);
        press(1, 1'b1);
        step(1);
        chk(event_count, 32'h0);
        chk(length_count, 32'h1);
        press(5, 1'b1);
        step(1);
        chk(length_count, 32'h0);
        want = TERM_ZERO;
        step(2);
    endtask : t_count
    task automatic t_mode;
        default_control_mode_setting = MODE_TORQUE;
        func_code[6] = FN_MODE_SWITCH;
        func_code[7] = FN_TORQUE_INHIBIT;
        step(2);
        chk(control_mode, MODE_TORQUE);
        press(6, 1'b1);
        chk(control_mode, MODE_SPEED);
        default_control_mode_setting = MODE_SPEED;
        step(2);
        chk(control_mode, MODE_TORQUE);
        press(7, 1'b1);
        chk(control_mode, MODE_SPEED);
        want = TERM_ZERO;
        step(2);
    endtask : t_mode
    task automatic t_pulse;
        func_code[2] = FN_PULSE_IN;
        func_code[3] = FN_RESERVED;
        step(2);
        chk(pulse_train_enable, 1'b0);
        func_code[9] = FN_PULSE_IN;
        want[2] = 1'b1;
        want[3] = 1'b1;
        press(9, 1'b1);
        chk(pulse_train_enable, 1'b1);
        chk(fast_pulse_input, 1'b1);
        chk({24'h0, lv}, 32'h0);
        step(1);
        chk(fast_pulse_input, 1'b0);
        want = TERM_ZERO;
        step(2);
    endtask : t_pulse
    task automatic t_fault;
        func_code[8] = FN_EXT_FAULT_NC;
        press(8, 1'b1);
        chk(external_fault_report, 1'b1);
        press(8, 1'b0);
        chk(fault_stop, 1'b1);
        fault_clear = 1'b1;
        step(2);
        fault_clear = 1'b0;
        chk(external_fault_report, 1'b0);
    endtask : t_fault
    task automatic t_source;
        func_code[0] = FN_SRC_SWITCH_2;
        func_code[1] = FN_EXT_STOP_1;
        func_code[4] = FN_GAIN_SWITCH;
        func_code[5] = FN_LOOP_DIR_INV;
        cmd_source_setting = SRC_TERMINAL;
        gain_set_switch_source = GAIN_SRC_TERMINAL;
        loop_direction_setting = 1'b1;
        want[0] = 1'b1;
        want[4] = 1'b1;
        want[5] = 1'b1;
        press(1, 1'b1);
        chk(cmd_source, SRC_COMM);
        chk(gain_select, 1'b1);
        chk(loop_direction, 1'b0);
        chk(panel_stop_req, 1'b0);
        press(1, 1'b0);
        cmd_source_setting = SRC_PANEL;
        gain_set_switch_source = 2'h2;
        press(1, 1'b1);
        chk(panel_stop_req, 1'b1);
        chk(cmd_source, SRC_PANEL);
        chk(gain_select, 1'b0);
        step(1);
        chk(panel_stop_req, 1'b0);
        want = TERM_ZERO;
        step(2);
        chk(loop_direction, 1'b1);
    endtask : t_source
    task automatic t_stops;
        func_code[2] = FN_SEQ_RESET;
        func_code[6] = FN_EMERGENCY_STOP;
        func_code[7] = FN_EXT_STOP_2;
        cmd_source_setting = SRC_COMM;
        want[2] = 1'b1;
        want[7] = 1'b1;
        press(6, 1'b1);
        chk(seq_reset, 1'b1);
        chk(current_limit_hold, 1'b1);
        chk(decel4_stop, 1'b1);
        want = TERM_ZERO;
        step(2);
        chk(seq_reset, 1'b0);
        chk(emergency_stop, 1'b1);
        motor_stopped = 1'b1;
        step(2);
        motor_stopped = 1'b0;
        chk(emergency_stop, 1'b0);
        chk(decel4_stop, 1'b0);
    endtask : t_stops

    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end
    initial begin
        step(6);
        resetn = 1'b1;
        step(1);
        chk(cmd_source, SRC_PANEL);
        t_levels();
        t_count();
        t_mode();
        t_pulse();
        t_fault();
        t_source();
        t_stops();
        wrap_up();
    end
endmodule : testbench
